/* sws_power_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Low wake-time word, read/write, reset zero, used only asleep with timer wake.
// - High wake-time word ignored unless 64-bit comparison is enabled.
// - Asleep: wait minimum dwell, then leave on timer or pin wake.
// - Asleep dwell counts the selected clock, possibly the slow oscillator.
// - Resume phases: wait dwell, then advance once all enabled supplies good.
// - Five-bit dwell field gives 2^n cycles; reset value 16.
// - Bit 14 gates the tile clock in that state; resets zero.
// - Bit 9 selects analogue regulator modulation, PWM or PFM.
// - Bit 8 selects core regulator modulation, PWM or PFM.
// - Bit 5 enables the I/O supply; reset 0 asleep, 1 resuming.
// - Bit 4 enables the PLL regulator; reset 1 only in phase two.
// - Bit 1 reads analogue enable: 0, 0, 1 for the three states.
// - Bit 0 enables the core regulator; reset 1 only in phase two.
// - Control bits enable timer wake and select 64-bit compare; reset zero.
// - Control bits enable pin wake and choose its level; polarity resets one.
// - Self-clearing sleep-initiate bit honoured only while running.
module sws_power_sequencer (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    output logic [31:0]      regRdData,
    output logic             regRdValid,
    // wake sources and supply feedback
    input  wire logic [63:0] rtcCount,
    input  wire logic        wakePin,
    input  wire logic        coreGood,
    input  wire logic        analogGood,
    input  wire logic        ioGood,
    input  wire logic        pllGood,
    // supply controls
    output logic             tileClockOff,
    output logic             analogPfm,
    output logic             corePfm,
    output logic             ioSupplyEn,
    output logic             pllSupplyEn,
    output logic             analogSupplyEn,
    output logic             coreSupplyEn,
    output sws_pkg::sws_state_e seqState
);
    import sws_pkg::*;

    // the slow divider counter is 11 bits wide
    if (SLOW_DIV < 1 || SLOW_DIV > 2047) begin : gen_div_check
        $error("slow clock divider out of range");
    end

    // configuration registers
    logic [31:0]  genCtrl,    next_genCtrl;
    logic [31:0]  wakeLow,    next_wakeLow;
    logic [31:0]  wakeHigh,   next_wakeHigh;
    logic [31:0]  sleepCfg,   next_sleepCfg;
    logic [31:0]  resume1Cfg, next_resume1Cfg;
    logic [31:0]  resume2Cfg, next_resume2Cfg;
    logic [31:0]  next_regRdData;
    // sequencer
    sws_state_e   next_seqState;
    logic [6:0]   supply,     next_supply;
    logic         dwellStart, next_dwellStart;
    logic [10:0]  slowCnt,    next_slowCnt;
    logic         slowTick,   next_slowTick;
    logic         dwellTick;
    logic         dwellDone;
    logic [4:0]   dwellLog2;
    logic         timerWake;
    logic         pinWake;
    logic         suppliesGood;
    logic         leaveRunning;

    function automatic logic [31:0] cfgRead(input logic [31:0] cfg, input logic anaEn);
        cfgRead = (cfg & CFG_WR_MASK) | (32'(anaEn) << CFG_ANALOG_EN);
    endfunction : cfgRead

    function automatic logic [6:0] cfgSupply(input logic [31:0] cfg, input logic anaEn);
        cfgSupply = {cfg[CFG_TILE_CLK_OFF], cfg[CFG_ANALOG_PFM], cfg[CFG_CORE_PFM],
                     cfg[CFG_IO_EN], cfg[CFG_PLL_EN], anaEn, cfg[CFG_CORE_EN]};
    endfunction : cfgSupply

    // wake conditions
    always_comb begin
        if (genCtrl[GEN_TIMER_64]) begin
            timerWake = rtcCount >= {wakeHigh, wakeLow};
        end else begin
            timerWake = rtcCount[31:0] >= wakeLow;
        end
        timerWake = timerWake && genCtrl[GEN_TIMER_WAKE_EN];
        pinWake = genCtrl[GEN_PIN_WAKE_EN] && (wakePin == genCtrl[GEN_PIN_POLARITY]);
        suppliesGood = (!supply[0] || coreGood) && (!supply[1] || analogGood)
                    && (!supply[2] || pllGood) && (!supply[3] || ioGood);
        leaveRunning = (seqState == ST_RUNNING) && genCtrl[GEN_SLEEP_INIT];
        // asleep counts at the slow rate unless the fast clock is selected
        dwellTick = (seqState != ST_ASLEEP) || genCtrl[GEN_SLEEP_CLK_SEL] || slowTick;
    end

    // register file
    always_comb begin
        next_genCtrl    = genCtrl;
        next_wakeLow    = wakeLow;
        next_wakeHigh   = wakeHigh;
        next_sleepCfg   = sleepCfg;
        next_resume1Cfg = resume1Cfg;
        next_resume2Cfg = resume2Cfg;
        next_regRdData  = regRdData;
        if (leaveRunning) begin
            next_genCtrl[GEN_SLEEP_INIT] = 1'b0;
        end
        if (regWrEn) begin
            case (regAddr)
                OFS_GEN_CTRL: begin
                    next_genCtrl[5:2] = regWrData[5:2];
                    next_genCtrl[GEN_SLEEP_CLK_SEL] = regWrData[GEN_SLEEP_CLK_SEL];
                    if (seqState == ST_RUNNING && !leaveRunning) begin
                        next_genCtrl[GEN_SLEEP_INIT] = regWrData[GEN_SLEEP_INIT]
                                                     | genCtrl[GEN_SLEEP_INIT];
                    end
                end
                OFS_WAKE_TIME_LOW:  next_wakeLow    = regWrData;
                OFS_WAKE_TIME_HIGH: next_wakeHigh   = regWrData;
                OFS_SLEEP_CFG:      next_sleepCfg   = regWrData & CFG_WR_MASK;
                OFS_RESUME1_CFG:    next_resume1Cfg = regWrData & CFG_WR_MASK;
                OFS_RESUME2_CFG:    next_resume2Cfg = regWrData & CFG_WR_MASK;
                default: ;
            endcase
        end
        if (regRdEn) begin
            case (regAddr)
                OFS_GEN_CTRL:       next_regRdData = genCtrl & 32'h0000_003F;
                OFS_WAKE_TIME_LOW:  next_regRdData = wakeLow;
                OFS_WAKE_TIME_HIGH: next_regRdData = wakeHigh;
                OFS_SLEEP_CFG:      next_regRdData = cfgRead(sleepCfg, SLEEP_ANALOG_EN);
                OFS_RESUME1_CFG:    next_regRdData = cfgRead(resume1Cfg, RESUME1_ANALOG_EN);
                OFS_RESUME2_CFG:    next_regRdData = cfgRead(resume2Cfg, RESUME2_ANALOG_EN);
                default:            next_regRdData = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            genCtrl    <= GEN_RESET;
            wakeLow    <= 32'h0;
            wakeHigh   <= 32'h0;
            sleepCfg   <= SLEEP_CFG_RESET;
            resume1Cfg <= RESUME1_CFG_RESET;
            resume2Cfg <= RESUME2_CFG_RESET;
            regRdData  <= 32'h0;
            regRdValid <= 1'b0;
        end else begin
            genCtrl    <= next_genCtrl;
            wakeLow    <= next_wakeLow;
            wakeHigh   <= next_wakeHigh;
            sleepCfg   <= next_sleepCfg;
            resume1Cfg <= next_resume1Cfg;
            resume2Cfg <= next_resume2Cfg;
            regRdData  <= next_regRdData;
            regRdValid <= regRdEn;
        end
    end

    // sequencer
    always_comb begin
        next_seqState   = seqState;
        next_dwellStart = 1'b0;
        next_slowCnt    = slowCnt + 11'h1;
        next_slowTick   = 1'b0;
        dwellLog2       = sleepCfg[CFG_DWELL_LSB +: CFG_DWELL_W];
        if (slowCnt == 11'(SLOW_DIV - 1)) begin
            next_slowCnt  = 11'h0;
            next_slowTick = 1'b1;
        end
        case (seqState)
            ST_RUNNING:  if (leaveRunning) next_seqState = ST_GOSLEEP1;
            ST_GOSLEEP1: next_seqState = ST_GOSLEEP2;
            ST_GOSLEEP2: next_seqState = ST_ASLEEP;
            ST_ASLEEP:   if (!dwellStart && dwellDone && (timerWake || pinWake))
                             next_seqState = ST_RESUME1;
            ST_RESUME1:  if (!dwellStart && dwellDone && suppliesGood)
                             next_seqState = ST_RESUME2;
            ST_RESUME2:  if (!dwellStart && dwellDone && suppliesGood)
                             next_seqState = ST_RUNNING;
            default:     next_seqState = ST_RUNNING;
        endcase
        case (next_seqState)
            ST_ASLEEP: begin
                next_supply = cfgSupply(sleepCfg, SLEEP_ANALOG_EN);
            end
            ST_RESUME1: begin
                next_supply = cfgSupply(resume1Cfg, RESUME1_ANALOG_EN);
                dwellLog2   = resume1Cfg[CFG_DWELL_LSB +: CFG_DWELL_W];
            end
            ST_RESUME2: begin
                next_supply = cfgSupply(resume2Cfg, RESUME2_ANALOG_EN);
                dwellLog2   = resume2Cfg[CFG_DWELL_LSB +: CFG_DWELL_W];
            end
            default: next_supply = RUNNING_SUPPLY;
        endcase
        if (next_seqState != seqState) begin
            next_dwellStart = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seqState   <= ST_RUNNING;
            supply     <= RUNNING_SUPPLY;
            dwellStart <= 1'b0;
            slowCnt    <= 11'h0;
            slowTick   <= 1'b0;
        end else begin
            seqState   <= next_seqState;
            supply     <= next_supply;
            dwellStart <= next_dwellStart;
            slowCnt    <= next_slowCnt;
            slowTick   <= next_slowTick;
        end
    end

    logic [4:0] dwellLog2Q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dwellLog2Q <= 5'h10;
        end else begin
            dwellLog2Q <= dwellLog2;
        end
    end

    sws_dwell_timer u_dwell (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .start      (dwellStart),
        .tick       (dwellTick),
        .log2Cycles (dwellLog2Q),
        .expired    (dwellDone)
    );

    always_comb begin
        {tileClockOff, analogPfm, corePfm, ioSupplyEn} = supply[6:3];
        pllSupplyEn    = supply[2];
        analogSupplyEn = supply[1];
        coreSupplyEn   = supply[0];
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_asleep_exit_cause: assert property (
        seqState == ST_ASLEEP && next_seqState == ST_RESUME1 |-> dwellDone && (timerWake || pinWake))
        else $error("left asleep without wake or dwell");
    chk_resume_good: assert property (
        seqState == ST_RESUME2 && next_seqState == ST_RUNNING |-> suppliesGood && dwellDone)
        else $error("left resume two with supplies not good");
    chk_order_gosleep: assert property (
        seqState == ST_GOSLEEP1 |=> seqState == ST_GOSLEEP2 ##1 seqState == ST_ASLEEP)
        else $error("go-sleep order broken");
    chk_sleep_init_clear: assert property (
        leaveRunning |=> !genCtrl[GEN_SLEEP_INIT] && seqState == ST_GOSLEEP1)
        else $error("sleep initiate not self-cleared");
    chk_init_only_running: assert property (
        seqState != ST_RUNNING |-> !genCtrl[GEN_SLEEP_INIT])
        else $error("sleep initiate held outside running");
    chk_supply_entry: assert property (
        $changed(seqState) && seqState == ST_ASLEEP |-> ioSupplyEn == sleepCfg[CFG_IO_EN]
        && coreSupplyEn == sleepCfg[CFG_CORE_EN] && tileClockOff == sleepCfg[CFG_TILE_CLK_OFF])
        else $error("asleep supplies not applied");
    chk_analog_fixed: assert property (
        seqState == ST_RESUME2 |-> analogSupplyEn)
        else $error("analogue enable wrong in resume two");
    chk_timer_32bit: assert property (
        !genCtrl[GEN_TIMER_64] && genCtrl[GEN_TIMER_WAKE_EN] && rtcCount[31:0] >= wakeLow
        |-> timerWake)
        else $error("32-bit wake compare wrong");
    chk_dwell_min: assert property (
        $rose(seqState == ST_RESUME1) && resume1Cfg[20:16] == 5'h2 |-> seqState == ST_RESUME1 [*4])
        else $error("resume one dwell too short");
    chk_read_latency: assert property (
        regRdEn && regAddr == OFS_WAKE_TIME_LOW |=> regRdValid && regRdData == $past(wakeLow))
        else $error("wake time read wrong");

endmodule : sws_power_sequencer
`default_nettype wire

/* sws_pkg.sv */
`default_nettype none
package sws_pkg;

    // register byte offsets
    localparam logic [7:0]  OFS_GEN_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_WAKE_TIME_LOW   = 8'h04;
    localparam logic [7:0]  OFS_WAKE_TIME_HIGH  = 8'h08;
    localparam logic [7:0]  OFS_SLEEP_CFG       = 8'h0C;
    localparam logic [7:0]  OFS_RESUME1_CFG     = 8'h10;
    localparam logic [7:0]  OFS_RESUME2_CFG     = 8'h14;

    // general control fields
    localparam int          GEN_SLEEP_CLK_SEL   = 0;
    localparam int          GEN_SLEEP_INIT      = 1;
    localparam int          GEN_PIN_WAKE_EN     = 2;
    localparam int          GEN_PIN_POLARITY    = 3;
    localparam int          GEN_TIMER_WAKE_EN   = 4;
    localparam int          GEN_TIMER_64        = 5;
    localparam logic [31:0] GEN_RESET           = 32'h0000_0008;

    // supply configuration fields
    localparam int          CFG_DWELL_LSB       = 16;
    localparam int          CFG_DWELL_W         = 5;
    localparam int          CFG_TILE_CLK_OFF    = 14;
    localparam int          CFG_ANALOG_PFM      = 9;
    localparam int          CFG_CORE_PFM        = 8;
    localparam int          CFG_IO_EN           = 5;
    localparam int          CFG_PLL_EN          = 4;
    localparam int          CFG_ANALOG_EN       = 1;
    localparam int          CFG_CORE_EN         = 0;
    localparam logic [31:0] CFG_WR_MASK         = 32'h001F_4331;

    // reset values of the writable parts, and the read-only analogue enable
    localparam logic [31:0] SLEEP_CFG_RESET     = 32'h0010_0000;
    localparam logic [31:0] RESUME1_CFG_RESET   = 32'h0010_0020;
    localparam logic [31:0] RESUME2_CFG_RESET   = 32'h0010_0031;
    localparam logic        SLEEP_ANALOG_EN     = 1'b0;
    localparam logic        RESUME1_ANALOG_EN   = 1'b0;
    localparam logic        RESUME2_ANALOG_EN   = 1'b1;

    // supplies while running: {tileClkOff, anaPfm, corePfm, io, pll, ana, core}
    localparam logic [6:0]  RUNNING_SUPPLY      = 7'h0F;

    // timing
    localparam int          CLK_HZ              = 50_000_000;
    localparam int          SLOW_CLK_HZ         = 31_250;
    localparam int          SLOW_DIV            = CLK_HZ / SLOW_CLK_HZ;

    typedef enum logic [5:0] {
        ST_RUNNING  = 6'b000001,
        ST_GOSLEEP1 = 6'b000010,
        ST_GOSLEEP2 = 6'b000100,
        ST_ASLEEP   = 6'b001000,
        ST_RESUME1  = 6'b010000,
        ST_RESUME2  = 6'b100000
    } sws_state_e;

endpackage : sws_pkg
`default_nettype wire

/* sws_dwell_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sws_dwell_timer (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // control
    input  wire logic                          start,
    input  wire logic                          tick,
    input  wire logic [sws_pkg::CFG_DWELL_W-1:0] log2Cycles,
    // status
    output logic                               expired
);
    import sws_pkg::*;

    logic [31:0]            count;
    logic [31:0]            target;
    logic [31:0]            next_count;
    logic [31:0]            next_target;
    logic                   next_expired;

    // start latches 2^n; expired rises on the 2^n-th tick after it
    always_comb begin
        next_count   = count;
        next_target  = target;
        next_expired = expired;
        if (start) begin
            next_count   = 32'h0;
            next_target  = 32'h1 << log2Cycles;
            next_expired = 1'b0;
        end else if (tick && !expired) begin
            next_count = count + 32'h1;
            if (next_count == target) begin
                next_expired = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count   <= 32'h0;
            target  <= 32'h1;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            target  <= next_target;
            expired <= next_expired;
        end
    end

endmodule : sws_dwell_timer
`default_nettype wire

/* sws_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sws_supply_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // settling time of a supply, in cycles
    input  wire logic [7:0]  goodDelay,
    // supply enables and good flags: {core, analog, io, pll}
    input  wire logic [3:0]  supplyEn,
    output logic      [3:0]  supplyGood,
    // free-running real-time counter
    output logic      [63:0] rtcCount
);
    logic [7:0] onCnt [4];

    // a supply reports good only after being enabled for goodDelay cycles,
    // and drops its good flag on the first clock edge after it is disabled
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rtcCount   <= 64'h0;
            supplyGood <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                onCnt[i] <= 8'h00;
            end
        end else begin
            rtcCount <= rtcCount + 64'h1;
            for (int i = 0; i < 4; i++) begin
                if (!supplyEn[i]) begin
                    onCnt[i] <= 8'h00;
                end else if (onCnt[i] != 8'hFF) begin
                    onCnt[i] <= onCnt[i] + 8'h01;
                end
                supplyGood[i] <= supplyEn[i] && (onCnt[i] >= goodDelay);
            end
        end
    end
endmodule : sws_supply_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sws_pkg::*;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end

    typedef struct {sws_state_e st; logic [6:0] sup; int minCyc;} sws_note_s;

    logic        mclk, sys_rst, regWrEn, regRdEn, regRdValid, wakePin;
    logic [7:0]  regAddr, goodDelay;
    logic [31:0] regWrData, regRdData;
    logic [63:0] rtcCount;
    logic        coreGood, analogGood, ioGood, pllGood;
    logic        tileClockOff, analogPfm, corePfm, ioSupplyEn, pllSupplyEn;
    logic        analogSupplyEn, coreSupplyEn;
    sws_state_e  seqState;
    logic [6:0]  supNow;
    logic [15:0] lfsr;
    int          n_fail, num_checks, cyc, enterCyc;
    logic [31:0] rdQ[$];
    sws_note_s   stQ[$];
    sws_note_s   curNote;
    logic [7:0]  ofs[5];
    logic        anaBit[5];

    assign supNow = {tileClockOff, analogPfm, corePfm, ioSupplyEn, pllSupplyEn,
                     analogSupplyEn, coreSupplyEn};

    sws_power_sequencer u_dut (.mclk(mclk), .sys_rst(sys_rst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .rtcCount(rtcCount), .wakePin(wakePin), .coreGood(coreGood),
        .analogGood(analogGood), .ioGood(ioGood), .pllGood(pllGood),
        .tileClockOff(tileClockOff), .analogPfm(analogPfm), .corePfm(corePfm),
        .ioSupplyEn(ioSupplyEn), .pllSupplyEn(pllSupplyEn), .analogSupplyEn(analogSupplyEn),
        .coreSupplyEn(coreSupplyEn), .seqState(seqState));

    sws_supply_model u_supplies (.mclk(mclk), .sys_rst(sys_rst), .goodDelay(goodDelay),
        .supplyEn({coreSupplyEn, analogSupplyEn, ioSupplyEn, pllSupplyEn}),
        .supplyGood({coreGood, analogGood, ioGood, pllGood}), .rtcCount(rtcCount));

    always #10 mclk = ~mclk;

    function automatic logic [31:0] rnd32();
        for (int i = 0; i < 32; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
        return {lfsr, lfsr ^ 16'hA5C3};
    endfunction : rnd32

    // read-back view of a supply configuration word
    function automatic logic [31:0] cfgView(logic [31:0] w, logic ana);
        return (w & CFG_WR_MASK) | {30'h0, ana, 1'b0};
    endfunction : cfgView

    function automatic logic [6:0] supOf(logic [31:0] c);
        return {c[14], c[9], c[8], c[5], c[4], c[1], c[0]};
    endfunction : supOf

    // one register access; a read also notes the value it should return
    task automatic regOp(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1;
        if (!wr) begin
            rdQ.push_back(d);
        end
        regWrEn   = wr;
        regRdEn   = !wr;
        regAddr   = a;
        regWrData = wr ? d : 32'h0;
        @(posedge mclk);
        #1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    endtask : regOp

    task automatic note(input sws_state_e st, input logic [6:0] sup, input int minCyc);
        sws_note_s n;
        n = '{st, sup, minCyc};
        stQ.push_back(n);
    endtask : note

    // program the three states, then start a sleep sequence
    task automatic doSleep(input logic [31:0] gen, sl, r1, r2, input int mSl, mR1, mR2);
        regOp(1'b1, OFS_SLEEP_CFG, sl);
        regOp(1'b1, OFS_RESUME1_CFG, r1);
        regOp(1'b1, OFS_RESUME2_CFG, r2);
        regOp(1'b1, OFS_GEN_CTRL, gen);
        note(ST_GOSLEEP1, RUNNING_SUPPLY, 1);
        note(ST_GOSLEEP2, RUNNING_SUPPLY, 1);
        note(ST_ASLEEP, supOf(cfgView(sl, SLEEP_ANALOG_EN)), mSl);
        note(ST_RESUME1, supOf(cfgView(r1, RESUME1_ANALOG_EN)), mR1);
        note(ST_RESUME2, supOf(cfgView(r2, RESUME2_ANALOG_EN)), mR2);
        note(ST_RUNNING, RUNNING_SUPPLY, 0);
        regOp(1'b1, OFS_GEN_CTRL, gen | 32'h2);
    endtask : doSleep

    task automatic waitDone(input logic [31:0] gen);
        for (int i = 0; i < 20000 && stQ.size() != 0; i++) begin
            @(posedge mclk);
        end
        regOp(1'b0, OFS_GEN_CTRL, gen);
    endtask : waitDone

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // watcher: every state change and every read result is matched to the oldest note
    always @(posedge mclk) begin
        if (!sys_rst && seqState !== curNote.st) begin
            `CHK(cyc - enterCyc >= curNote.minCyc, 1'b1)
            if (stQ.size() == 0) begin
                n_fail++;
                $display("[ERR] %0t unexpected state %0h", $time, seqState);
                curNote.st = seqState;
            end else begin
                curNote = stQ.pop_front();
                `CHK(seqState, curNote.st)
                `CHK(supNow, curNote.sup)
            end
            enterCyc = cyc;
        end
        if (regRdValid === 1'b1) begin
            if (rdQ.size() == 0) begin
                n_fail++;
                $display("[ERR] %0t unexpected read data", $time);
            end else begin
                `CHK(regRdData, rdQ.pop_front())
            end
        end
        cyc++;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        $display("[ERR] %0t run did not finish", $time);
        summarize();
    end

    initial begin
        logic [31:0] w;
        mclk = 1'b0; sys_rst = 1'b1; regWrEn = 1'b0; regRdEn = 1'b0;
        regAddr = 8'h00; regWrData = 32'h0; wakePin = 1'b0; goodDelay = 8'h02;
        lfsr = 16'h004B; cyc = 0; enterCyc = 0;
        n_fail = 0; num_checks = 0;
        curNote = '{ST_RUNNING, RUNNING_SUPPLY, 0};
        ofs = '{OFS_WAKE_TIME_LOW, OFS_WAKE_TIME_HIGH, OFS_SLEEP_CFG, OFS_RESUME1_CFG,
                OFS_RESUME2_CFG};
        anaBit = '{1'b0, 1'b0, SLEEP_ANALOG_EN, RESUME1_ANALOG_EN, RESUME2_ANALOG_EN};
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        `CHK(supNow, RUNNING_SUPPLY)
        // reset values, then an unmapped place
        regOp(1'b0, OFS_GEN_CTRL, GEN_RESET);
        regOp(1'b0, OFS_WAKE_TIME_LOW, 32'h0);
        regOp(1'b0, OFS_WAKE_TIME_HIGH, 32'h0);
        regOp(1'b0, OFS_SLEEP_CFG, cfgView(SLEEP_CFG_RESET, SLEEP_ANALOG_EN));
        regOp(1'b0, OFS_RESUME1_CFG, cfgView(RESUME1_CFG_RESET, RESUME1_ANALOG_EN));
        regOp(1'b0, OFS_RESUME2_CFG, cfgView(RESUME2_CFG_RESET, RESUME2_ANALOG_EN));
        regOp(1'b0, 8'h18, 32'h0);
        // random write and read-back; read-only and reserved bits must not stick
        for (int k = 0; k < 15; k++) begin
            w = rnd32();
            regOp(1'b1, ofs[k % 5], w);
            regOp(1'b0, ofs[k % 5], (k % 5 < 2) ? w : cfgView(w, anaBit[k % 5]));
        end
        // pin wake at high level, fast dwell clock, random supply bits
        wakePin = 1'b1;
        doSleep(32'h0D, (rnd32() & ~32'h001F_0000) | 32'h0003_0000,
                (rnd32() & ~32'h001F_0000) | 32'h0002_0000,
                (rnd32() & ~32'h001F_0000) | 32'h0004_0000, 8, 4, 16);
        waitDone(32'h0D);
        // 32-bit timer wake, high word ignored, slow dwell clock, slow supplies
        wakePin   = 1'b0;
        goodDelay = 8'd40;
        regOp(1'b1, OFS_WAKE_TIME_LOW, 32'h0);
        regOp(1'b1, OFS_WAKE_TIME_HIGH, 32'hFFFF_FFFF);
        doSleep(32'h10, 32'h0001_0000, 32'h21, 32'h31, SLOW_DIV, 40, 40);
        waitDone(32'h10);
        // 64-bit compare not yet met, pin at idle level; a late initiate is refused
        goodDelay = 8'h02;
        wakePin   = 1'b1;
        regOp(1'b1, OFS_WAKE_TIME_HIGH, 32'h1);
        doSleep(32'h35, 32'h0000_4300, 32'h20, 32'h31, 250, 1, 1);
        repeat (100) @(posedge mclk);
        regOp(1'b1, OFS_GEN_CTRL, 32'h37);
        repeat (200) @(posedge mclk);
        #1;
        wakePin = 1'b0;
        waitDone(32'h35);
        // 64-bit compare met: high word zero, low word a little ahead of the counter
        regOp(1'b1, OFS_WAKE_TIME_HIGH, 32'h0);
        regOp(1'b1, OFS_WAKE_TIME_LOW, rtcCount[31:0] + 32'h0000_01F4);
        doSleep(32'h31, 32'h0, 32'h20, 32'h31, 400, 1, 1);
        waitDone(32'h31);
        repeat (20) @(posedge mclk);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
